// ---- logic/psm_regs.svh ----
// Constants for the program space map and stack check block.
// Assumes inclusion by the module or the bench only.
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
`define PSM_RESET_PC 24'h00_0000
`define PSM_RESET_GOTO_TGT 24'h00_0002
`define PSM_USER_TOP 24'h7F_FFFF
`define PSM_VEC_END 24'h00_0200
`define PSM_IVT_LO 24'h00_0004
`define PSM_IVT_HI 24'h00_00FF
`define PSM_AIVT_LO 24'h00_0104
`define PSM_AIVT_HI 24'h00_01FF
`define PSM_EE_BASE 24'h7F_FE00
`define PSM_EE_WORDS 256
`define PSM_CFG_BASE 24'hF8_0000
`define PSM_CFG_LAST 24'hF8_000E
`define PSM_STACK_FLOOR 16'h0800
`define PSM_PC_STEP 23'h00_0002
`define PSM_APB_STACK_LIMIT_REG 12'h000
`define PSM_APB_SP 12'h004
`define PSM_APB_TABLE_PAGE_REG 12'h008
`define PSM_APB_VISIBILITY_PAGE_REG 12'h00C
`define PSM_APB_STATUS 12'h010
`define PSM_APB_SRL 12'h014
`define PSM_PROG_WORDS 1024
`endif

// ---- logic/psm_pkg.sv ----
// Types for the program space map and stack check block.
// Assumes nothing beyond the header of constants.
package psm_pkg;
    typedef enum logic [2:0] {
        PSM_RGN_VECTOR = 3'b000,
        PSM_RGN_CODE = 3'b001,
        PSM_RGN_UNIMP = 3'b010,
        PSM_RGN_EEPROM = 3'b011,
        PSM_RGN_CONFIG = 3'b100,
        PSM_RGN_DENIED = 3'b101
    } psm_region_e;
    typedef enum logic [1:0] {
        PSM_SRC_PC = 2'b00,
        PSM_SRC_TABLE = 2'b01,
        PSM_SRC_REMAP = 2'b10
    } psm_src_e;
    typedef enum logic [1:0] {
        PSM_PUSH_DATA = 2'b00,
        PSM_PUSH_CALL = 2'b01,
        PSM_PUSH_EXC = 2'b10
    } psm_push_e;
    typedef enum logic [0:0] {
        PSM_TRAP_IDLE = 1'b0,
        PSM_TRAP_WAIT = 1'b1
    } psm_trap_e;
endpackage

// ---- logic/psm_core.sv ----
// Program space address map, program word read-out and software stack checker.
// Assumes core fetch and table logic on clk_sys; registers reached over APB.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"

// What this block does
// [R1] Builds 24-bit program addresses from the 23-bit counter, table or remap.
// [R2] Plain users see only 000000h-7FFFFFh; config space needs table access, page bit 7.
// [R3] Each program location is a lower word at even, upper word at odd address.
// [R4] Upper byte of the upper word reads as zero.
// [R5] Counter stays even and steps by two per instruction word.
// [R6] Fetch starts at 000000h after reset; jump target lives at 000002h.
// [R7] Vectors below 000200h: primary 000004h-0000FFh, alternate 000104h-0001FFh.
// [R8] 256-word 16-bit data nonvolatile array from 7FFE00, reached by table ops.
// [R9] Eight configuration words sit between F80000 and F8000E.
// [R10] Stack pointer marks first free word; push post-increments, pop pre-decrements.
// [R11] Call pushes clear the byte beside the counter's top byte.
// [R12] Exception pushes place the low status byte beside the counter's top byte.
// [R13] Limit bit 0 always zero; other limit bits set after reset.
// [R14] Every push effective address is compared with the limit; pops are not.
// [R15] Push at pointer equal to limit is fine; next push beyond traps.
// [R16] Pointer below 0800h raises a stack error trap.
// [R17] Software avoids stack-indirect reads just after writing the limit.
// [R18] Table address is table page joined with 16-bit address; page bit 7 picks config.
// [R19] Remap with address bit 15 set joins visibility page with low 15 bits.
// [R20] Unimplemented program addresses read zero without error.
// [R21] Stack error is a one-cycle trap request, held pending until acknowledged.
module psm_core
    import psm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pc_advance,
    input wire logic pc_backward,
    input wire logic pc_load,
    input wire logic [22:0] pc_load_value,
    input wire logic [1:0] fetch_src,
    input wire logic [15:0] data_ea,
    input wire logic table_read_op,
    input wire logic table_write_op,
    input wire logic [15:0] table_wdata,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [1:0] push_kind,
    input wire logic [15:0] push_data,
    input wire logic trap_ack,
    output logic [22:0] pc_q,
    output logic [23:0] prog_addr_q,
    output logic [2:0] region_q,
    output logic [15:0] prog_rdata_q,
    output logic access_denied_q,
    output logic [15:0] stack_ea_q,
    output logic [15:0] stack_wdata_q,
    output logic stack_trap_req_q,
    output logic stack_trap_pending_q
);
    // Local storage; program array is a small model of flash words
    logic [23:0] prog_mem [0:`PSM_PROG_WORDS-1];
    logic [15:0] ee_mem [0:`PSM_EE_WORDS-1];
    logic [15:0] cfg_mem [0:7];
    logic [15:0] stack_limit_reg;
    logic [15:0] stack_pointer_reg;
    logic [7:0] table_page_reg;
    logic [7:0] visibility_page_reg;
    logic [7:0] status_low_byte;
    logic [23:0] addr_d;
    logic [2:0] region_d;
    logic denied_d;
    logic [15:0] rdata_d;
    logic [15:0] sp_next;
    logic [15:0] sp_ea;
    logic stack_err;
    logic apb_wr;
    logic apb_rd;
    psm_trap_e trap_q;
    logic [22:0] pc_top_word;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Counter: even on load, steps by two, reset to vector zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= 23'h00_0000; // see [R6]
        end else if (pc_load) begin
            pc_q <= {pc_load_value[22:1], 1'b0}; // see [R5]
        end else if (pc_advance) begin
            pc_q <= pc_backward ? pc_q - `PSM_PC_STEP : pc_q + `PSM_PC_STEP; // see [R5]
        end
    end

    // Address formation per source
    always_comb begin
        addr_d = `PSM_RESET_PC;
        case (psm_src_e'(fetch_src))
            PSM_SRC_PC: addr_d = {1'b0, pc_q}; // see [R1]
            PSM_SRC_TABLE: addr_d = {table_page_reg, data_ea}; // see [R18]
            PSM_SRC_REMAP: addr_d = {1'b0, visibility_page_reg, data_ea[14:0]}; // see [R19]
            default: addr_d = {1'b0, pc_q};
        endcase
    end

    // Region decode; config only for table ops with page bit 7 set
    always_comb begin
        denied_d = 1'b0;
        region_d = PSM_RGN_UNIMP;
        if (addr_d[23]) begin
            region_d = PSM_RGN_CONFIG;
            // Config opens only while a table op is in flight; idle table cycles are denied
            denied_d = !(fetch_src == PSM_SRC_TABLE && table_page_reg[7] // see [R2]
                && (table_read_op || table_write_op));
            if (denied_d) begin
                region_d = PSM_RGN_DENIED;
            end
        end else if (addr_d < `PSM_VEC_END) begin
            region_d = PSM_RGN_VECTOR; // see [R7]
        end else if (addr_d >= `PSM_EE_BASE) begin
            region_d = PSM_RGN_EEPROM; // see [R8]
        end else if (addr_d[23:1] < 23'(`PSM_PROG_WORDS)) begin
            region_d = PSM_RGN_CODE;
        end
    end

    // Read-out: odd address is upper word with phantom byte zero
    always_comb begin
        rdata_d = 16'h0000; // see [R20]
        case (psm_region_e'(region_d))
            PSM_RGN_VECTOR, PSM_RGN_CODE: begin
                if (addr_d[0]) begin
                    rdata_d = {8'h00, prog_mem[addr_d[10:1]][23:16]}; // see [R3] [R4]
                end else begin
                    rdata_d = prog_mem[addr_d[10:1]][15:0]; // see [R3]
                end
            end
            PSM_RGN_EEPROM: rdata_d = ee_mem[addr_d[8:1]]; // see [R8]
            PSM_RGN_CONFIG: begin
                if (addr_d >= `PSM_CFG_BASE && addr_d <= `PSM_CFG_LAST && !addr_d[0]) begin
                    rdata_d = cfg_mem[addr_d[3:1]]; // see [R9]
                end
            end
            default: rdata_d = 16'h0000;
        endcase
    end

    // Registered map outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prog_addr_q <= 24'h00_0000;
            region_q <= 3'h0;
            prog_rdata_q <= 16'h0000;
            access_denied_q <= 1'b0;
        end else begin
            prog_addr_q <= addr_d;
            region_q <= region_d;
            prog_rdata_q <= rdata_d;
            access_denied_q <= denied_d;
        end
    end

    // Table writes into program, nonvolatile and config words
    always_ff @(posedge clk_sys) begin
        if (table_write_op && !denied_d && fetch_src == PSM_SRC_TABLE) begin
            if (region_d == PSM_RGN_EEPROM && !addr_d[0]) begin
                ee_mem[addr_d[8:1]] <= table_wdata; // see [R8]
            end else if (region_d == PSM_RGN_CONFIG && addr_d <= `PSM_CFG_LAST && !addr_d[0]) begin
                cfg_mem[addr_d[3:1]] <= table_wdata; // see [R9]
            end else if (region_d == PSM_RGN_CODE || region_d == PSM_RGN_VECTOR) begin
                if (addr_d[0]) begin
                    prog_mem[addr_d[10:1]][23:16] <= table_wdata[7:0];
                end else begin
                    prog_mem[addr_d[10:1]][15:0] <= table_wdata;
                end
            end
        end
    end

    // Stack effective address: push uses pointer, pop uses pointer minus two
    assign sp_ea = stack_pop ? stack_pointer_reg - 16'h0002 : stack_pointer_reg; // see [R10]
    assign sp_next = stack_push ? stack_pointer_reg + 16'h0002 : sp_ea; // see [R10]
    // Push beyond limit or any address under the floor is an error
    assign stack_err = (stack_push && (sp_ea > stack_limit_reg)) // see [R14] [R15]
        || ((stack_push || stack_pop) && (sp_ea < `PSM_STACK_FLOOR)); // see [R16]
    assign pc_top_word = pc_q;

    // Pushed word content by push kind
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stack_ea_q <= 16'h0000;
            stack_wdata_q <= 16'h0000;
        end else if (stack_push || stack_pop) begin
            stack_ea_q <= sp_ea;
            case (psm_push_e'(push_kind))
                PSM_PUSH_CALL: stack_wdata_q <= {8'h00, 1'b0, pc_top_word[22:16]}; // see [R11]
                PSM_PUSH_EXC: stack_wdata_q <= {status_low_byte, 1'b0, pc_top_word[22:16]}; // see [R12]
                default: stack_wdata_q <= push_data;
            endcase
        end
    end

    // Trap request pulse plus pending level; new error wins over acknowledge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trap_q <= PSM_TRAP_IDLE;
            stack_trap_req_q <= 1'b0;
            stack_trap_pending_q <= 1'b0;
        end else begin
            stack_trap_req_q <= stack_err && trap_q == PSM_TRAP_IDLE; // see [R21]
            case (trap_q)
                PSM_TRAP_IDLE: if (stack_err) begin
                    trap_q <= PSM_TRAP_WAIT;
                    stack_trap_pending_q <= 1'b1;
                end
                PSM_TRAP_WAIT: if (trap_ack && !stack_err) begin
                    trap_q <= PSM_TRAP_IDLE; // see [R21]
                    stack_trap_pending_q <= 1'b0;
                end
                default: trap_q <= PSM_TRAP_IDLE;
            endcase
        end
    end

    // Stack pointer, limit and pages; bus writes win over core steps
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stack_pointer_reg <= `PSM_STACK_FLOOR;
            stack_limit_reg <= 16'hFFFE; // Bit 0 clear, all other bits set; reads back as FFFE over APB
            table_page_reg <= 8'h00;
            visibility_page_reg <= 8'h00;
            status_low_byte <= 8'h00;
        end else if (apb_wr) begin
            case (paddr)
                `PSM_APB_STACK_LIMIT_REG: stack_limit_reg <= {pwdata[15:1], 1'b0}; // see [R13]
                `PSM_APB_SP: stack_pointer_reg <= {pwdata[15:1], 1'b0};
                `PSM_APB_TABLE_PAGE_REG: table_page_reg <= pwdata[7:0];
                `PSM_APB_VISIBILITY_PAGE_REG: visibility_page_reg <= pwdata[7:0];
                `PSM_APB_SRL: status_low_byte <= pwdata[7:0];
                default: status_low_byte <= status_low_byte;
            endcase
        end else if (stack_push || stack_pop) begin
            stack_pointer_reg <= sp_next; // see [R10]
        end
    end

    // APB slave: no wait states, data ready at access phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr inside {`PSM_APB_STACK_LIMIT_REG, `PSM_APB_SP,
                `PSM_APB_TABLE_PAGE_REG, `PSM_APB_VISIBILITY_PAGE_REG, `PSM_APB_STATUS, `PSM_APB_SRL});
            // Read data is latched in setup so that it stands through the access cycle
            if (apb_rd) begin
                case (paddr)
                    `PSM_APB_STACK_LIMIT_REG: prdata <= {16'h0000, stack_limit_reg};
                    `PSM_APB_SP: prdata <= {16'h0000, stack_pointer_reg};
                    `PSM_APB_TABLE_PAGE_REG: prdata <= {24'h00_0000, table_page_reg};
                    `PSM_APB_VISIBILITY_PAGE_REG: prdata <= {24'h00_0000, visibility_page_reg};
                    `PSM_APB_STATUS: prdata <= {30'h0000_0000, access_denied_q, stack_trap_pending_q};
                    `PSM_APB_SRL: prdata <= {24'h00_0000, status_low_byte};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks on the logic above
    a_pc_even: assert property (@(posedge clk_sys) disable iff (rst) pc_q[0] == 1'b0) // see [R5]
        else $error("counter is odd");
    a_pc_step: assert property (@(posedge clk_sys) disable iff (rst) // see [R5]
        pc_advance && !pc_load && !pc_backward |=> pc_q == $past(pc_q) + 23'h00_0002)
        else $error("counter step wrong");
    a_phantom_zero: assert property (@(posedge clk_sys) disable iff (rst) // see [R4]
        region_q == PSM_RGN_CODE && prog_addr_q[0] |-> prog_rdata_q[15:8] == 8'h00)
        else $error("phantom byte not zero");
    a_cfg_denied: assert property (@(posedge clk_sys) disable iff (rst) // see [R2]
        fetch_src == PSM_SRC_PC |=> !access_denied_q || prog_addr_q[23])
        else $error("denied outside config");
    a_limit_even: assert property (@(posedge clk_sys) disable iff (rst) !stack_limit_reg[0]) // see [R13]
        else $error("limit bit 0 set");
    a_limit_equal_ok: assert property (@(posedge clk_sys) disable iff (rst) // see [R15]
        stack_push && sp_ea == stack_limit_reg && sp_ea >= `PSM_STACK_FLOOR |=> !stack_trap_req_q)
        else $error("trap at limit");
    a_floor_trap: assert property (@(posedge clk_sys) disable iff (rst) // see [R16]
        (stack_push || stack_pop) && sp_ea < `PSM_STACK_FLOOR && !stack_trap_pending_q
        |=> stack_trap_req_q ##1 !stack_trap_req_q)
        else $error("floor trap missing");
    a_trap_held: assert property (@(posedge clk_sys) disable iff (rst) // see [R21]
        stack_trap_pending_q && !trap_ack |=> stack_trap_pending_q)
        else $error("trap not held");
    a_call_clear: assert property (@(posedge clk_sys) disable iff (rst) // see [R11]
        stack_push && push_kind == PSM_PUSH_CALL |=> stack_wdata_q[15:7] == 9'h000)
        else $error("call push top byte set");
    a_push_step: assert property (@(posedge clk_sys) disable iff (rst) // see [R10]
        stack_push && !apb_wr |=> stack_pointer_reg == $past(stack_pointer_reg) + 16'h0002)
        else $error("push step wrong");
    a_pop_step: assert property (@(posedge clk_sys) disable iff (rst) // see [R10]
        stack_pop && !stack_push && !apb_wr |=> stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002)
        else $error("pop step wrong");
    a_exc_byte: assert property (@(posedge clk_sys) disable iff (rst) // see [R12]
        stack_push && push_kind == PSM_PUSH_EXC |=> stack_wdata_q[15:8] == $past(status_low_byte))
        else $error("status byte missing");
    a_limit_trap: assert property (@(posedge clk_sys) disable iff (rst) // see [R15]
        stack_push && sp_ea > stack_limit_reg && !stack_trap_pending_q |=> stack_trap_req_q)
        else $error("limit trap missing");
    a_trap_pulse: assert property (@(posedge clk_sys) disable iff (rst) // see [R21]
        stack_trap_req_q |=> !stack_trap_req_q)
        else $error("trap request too long");
    a_trap_pend_set: assert property (@(posedge clk_sys) disable iff (rst) // see [R21]
        stack_trap_req_q |-> stack_trap_pending_q)
        else $error("request without pending");
    a_ack_clears: assert property (@(posedge clk_sys) disable iff (rst) // see [R21]
        stack_trap_pending_q && trap_ack && !stack_err |=> !stack_trap_pending_q)
        else $error("acknowledge ignored");
    a_user_half: assert property (@(posedge clk_sys) disable iff (rst) // see [R2]
        fetch_src != PSM_SRC_TABLE |=> !prog_addr_q[23])
        else $error("user access above half");
    a_vec_area: assert property (@(posedge clk_sys) disable iff (rst) // see [R7]
        region_q == PSM_RGN_VECTOR |-> prog_addr_q < `PSM_VEC_END)
        else $error("vector region wrong");
    a_ee_area: assert property (@(posedge clk_sys) disable iff (rst) // see [R8]
        region_q == PSM_RGN_EEPROM |-> prog_addr_q >= `PSM_EE_BASE && !prog_addr_q[23])
        else $error("nonvolatile region wrong");
    a_unimp_zero: assert property (@(posedge clk_sys) disable iff (rst) // see [R20]
        region_q == PSM_RGN_UNIMP |-> prog_rdata_q == 16'h0000)
        else $error("unimplemented read not zero");
    a_denied_zero: assert property (@(posedge clk_sys) disable iff (rst) // see [R2]
        access_denied_q |-> region_q == PSM_RGN_DENIED && prog_rdata_q == 16'h0000)
        else $error("denied access leaks data");
    // Main scenarios worth seeing at least once
    c_trap: cover property (@(posedge clk_sys) stack_trap_req_q);
    c_denied: cover property (@(posedge clk_sys) access_denied_q);
    c_ack: cover property (@(posedge clk_sys) stack_trap_pending_q && trap_ack);
    c_cfg_read: cover property (@(posedge clk_sys) region_q == PSM_RGN_CONFIG);
    c_ee_read: cover property (@(posedge clk_sys) region_q == PSM_RGN_EEPROM);
endmodule
`default_nettype wire

// ---- tb/psm_core_model.sv ----
// Core exception-side model: acknowledges stack error traps.
// Assumes the clk_sys domain and the active-high rst of the block.
`timescale 1ns/1ps
`default_nettype none
module psm_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slow,
    input wire logic trap_req,
    output logic trap_ack
);
    logic [2:0] wait_q;
    logic busy_q;
    // Ack after 1 or 6 cycles; the slow case keeps pending visible longer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            trap_ack <= 1'b0;
        end else begin
            trap_ack <= 1'b0;
            if (trap_req) begin
                busy_q <= 1'b1;
                wait_q <= slow ? 3'h5 : 3'h0;
            end else if (busy_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                trap_ack <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/program_space_map_and_stack_check_bench.sv ----
// Self-checking bench: address map, program words and stack checks.
// Assumes psm_pkg, psm_core and psm_core_model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "psm_regs.svh"
module program_space_map_and_stack_check_bench import psm_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, seed = 32'h0001_0F93;
    logic pc_advance = 1'b0, pc_backward = 1'b0, pc_load = 1'b0, table_read_op = 1'b0;
    logic table_write_op = 1'b0, stack_push = 1'b0, stack_pop = 1'b0;
    logic pready, pslverr, access_denied_q, stack_trap_req_q, stack_trap_pending_q, trap_ack, rerr;
    logic [22:0] pc_load_value = 23'h00_0000, pc_q, pv;
    logic [1:0] fetch_src = 2'h0, push_kind = 2'h0;
    logic [15:0] data_ea = 16'h0000, table_wdata = 16'h0000, push_data = 16'h0000;
    logic [15:0] prog_rdata_q, stack_ea_q, stack_wdata_q, lim, sp, d, s;
    logic [23:0] prog_addr_q;
    logic [2:0] region_q;
    logic [23:0] map_a [9] = '{24'h00_0000, 24'h00_00FE, 24'h00_0104, 24'h00_01FE, 24'h00_0400,
        24'h01_0000, 24'h7F_FE00, 24'hF8_0000, 24'hF8_000E};
    logic [2:0] map_r [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    logic [23:0] wr_a [3] = '{24'h00_0400, 24'h00_0401, 24'h7F_FE02};
    int err_count = 0, cmp_count = 0, cyc = 0, n;
    psm_core uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pc_advance, .pc_backward, .pc_load, .pc_load_value, .fetch_src, .data_ea, .table_read_op,
        .table_write_op, .table_wdata, .stack_push, .stack_pop, .push_kind, .push_data, .trap_ack,
        .pc_q, .prog_addr_q, .region_q, .prog_rdata_q, .access_denied_q, .stack_ea_q, .stack_wdata_q,
        .stack_trap_req_q, .stack_trap_pending_q);
    psm_core_model u_core (.clk_sys, .rst, .slow, .trap_req(stack_trap_req_q), .trap_ack);
    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;
    function automatic logic [15:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction
    // Expected pushed word per push kind; t is the counter's top bits
    function automatic logic [15:0] push_word(input logic [1:0] k, input logic [15:0] v, input logic [7:0] b,
        input logic [6:0] t);
        return (k == PSM_PUSH_DATA) ? v : {(k == PSM_PUSH_EXC) ? b : 8'h00, 1'b0, t};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // APB master: setup, then access held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 40);
        // A slave that never answers is a failure, not a skipped transfer
        if (pready !== 1'b1) begin
            err_count++;
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic push, input logic [1:0] k, input logic [15:0] v);
        @(posedge clk_sys);
        stack_push <= push;
        stack_pop <= !push;
        push_kind <= k;
        push_data <= v;
        @(posedge clk_sys);
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        #1;
    endtask
    task automatic tbl(input logic wr, input logic [15:0] ea, input logic [15:0] v);
        @(posedge clk_sys);
        fetch_src <= PSM_SRC_TABLE;
        data_ea <= ea;
        table_wdata <= v;
        table_write_op <= wr;
        table_read_op <= !wr;
        @(posedge clk_sys);
        table_write_op <= 1'b0;
        table_read_op <= 1'b0;
        #1;
    endtask
    task automatic pcs(input logic ld, input logic adv, input logic bk, input logic [22:0] v);
        @(posedge clk_sys);
        fetch_src <= PSM_SRC_PC;
        pc_load <= ld;
        pc_load_value <= v;
        pc_advance <= adv;
        pc_backward <= bk;
        @(posedge clk_sys);
        pc_load <= 1'b0;
        pc_advance <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(pc_q, pv);
        chk(prog_addr_q, {1'b0, pv});
    endtask
    // Trap request within three cycles of the offending access
    task automatic trap_seen(input logic exp);
        n = 0;
        while (stack_trap_req_q !== 1'b1 && n < 3) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(stack_trap_req_q, exp);
    endtask
    task automatic trap_clear();
        n = 0;
        while (stack_trap_pending_q !== 1'b0 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(stack_trap_pending_q, 1'b0);
    endtask
    // Hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk(prog_addr_q, 24'h00_0000);
        apb(0, `PSM_APB_STACK_LIMIT_REG, 0);
        chk(rd[15:0], 16'hFFFE);
        apb(0, `PSM_APB_SP, 0);
        chk(rd[15:0], 16'h0800);
        apb(0, 12'h018, 0);
        chk({rerr, rd}, {1'b1, 32'h0000_0000});
        lim = nxt() | 16'h0001;
        apb(1, `PSM_APB_STACK_LIMIT_REG, {16'h0000, lim});
        apb(0, `PSM_APB_STACK_LIMIT_REG, 0);
        chk(rd[15:0], lim & 16'hFFFE);
        $display("test reset_regs done");
        // Odd load forced even, then forward and backward steps; top bits random for the push words
        d = nxt();
        pv = {d[6:0], nxt() & 16'hFFFE};
        pcs(1, 0, 0, pv | 23'h00_0001);
        pv = pv + 23'h00_0002;
        pcs(0, 1, 0, 0);
        pv = pv - 23'h00_0002;
        pcs(0, 1, 1, 0);
        $display("test counter done");
        for (int i = 0; i < 9; i++) begin
            apb(1, `PSM_APB_TABLE_PAGE_REG, {24'h00_0000, map_a[i][23:16]});
            tbl(0, map_a[i][15:0], 0);
            chk(prog_addr_q, map_a[i]);
            chk(region_q, map_r[i]);
            chk(access_denied_q, 1'b0);
            if (map_r[i] == PSM_RGN_UNIMP) begin
                chk(prog_rdata_q, 16'h0000);
            end
        end
        // Config page still selected but no table op in flight: refused
        @(posedge clk_sys);
        #1;
        chk(access_denied_q, 1'b1);
        chk({region_q, prog_rdata_q}, {3'h5, 16'h0000});
        d = nxt();
        sp = nxt() | 16'h8000;
        apb(1, `PSM_APB_VISIBILITY_PAGE_REG, {24'h00_0000, d[7:0]});
        @(posedge clk_sys);
        fetch_src <= PSM_SRC_REMAP;
        data_ea <= sp;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(prog_addr_q, {1'b0, d[7:0], sp[14:0]});
        $display("test map done");
        for (int i = 0; i < 3; i++) begin
            apb(1, `PSM_APB_TABLE_PAGE_REG, {24'h00_0000, wr_a[i][23:16]});
            d = nxt();
            tbl(1, wr_a[i][15:0], d);
            tbl(0, wr_a[i][15:0], 0);
            chk(prog_rdata_q, wr_a[i][0] ? {8'h00, d[7:0]} : d);
        end
        $display("test words done");
        s = nxt();
        apb(1, `PSM_APB_SP, 32'h0000_0900);
        apb(1, `PSM_APB_STACK_LIMIT_REG, 32'h0000_0F00);
        apb(1, `PSM_APB_SRL, {24'h00_0000, s[7:0]});
        for (int k = 0; k < 3; k++) begin
            d = nxt();
            op(1, k[1:0], d);
            chk(stack_ea_q, 16'h0900 + 16'(2 * k));
            chk(stack_wdata_q, push_word(k[1:0], d, s[7:0], pv[22:16]));
        end
        op(0, 0, 0);
        chk(stack_ea_q, 16'h0904);
        apb(0, `PSM_APB_SP, 0);
        chk(rd[15:0], 16'h0904);
        chk(stack_trap_pending_q, 1'b0);
        $display("test pushes done");
        // Limit check with a slow exception entry
        lim = 16'h0A00 + (nxt() & 16'h03FE);
        apb(1, `PSM_APB_STACK_LIMIT_REG, {16'h0000, lim});
        apb(1, `PSM_APB_SP, {16'h0000, lim - 16'h0002});
        slow <= 1'b1;
        op(1, PSM_PUSH_DATA, nxt());
        op(1, PSM_PUSH_DATA, nxt());
        trap_seen(1'b0);
        op(1, PSM_PUSH_DATA, nxt());
        trap_seen(1'b1);
        @(posedge clk_sys);
        #1;
        chk({stack_trap_req_q, stack_trap_pending_q}, 2'b01);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(stack_trap_pending_q, 1'b1);
        trap_clear();
        $display("test limit done");
        slow <= 1'b0;
        apb(1, `PSM_APB_SP, 32'h0000_0802);
        op(0, 0, 0);
        trap_seen(1'b0);
        op(0, 0, 0);
        trap_seen(1'b1);
        trap_clear();
        $display("test floor done");
        print_verdict();
    end
endmodule
`default_nettype wire
